/* File: design/adc_seq_regs.svh */
// register map, field positions, reset values and timing figures of the converter sequencer
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH

// ----------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------
`define IDX_MAIN_CTRL 8'h50
`define IDX_TIMING_CTRL 8'h51
`define IDX_RESULT 8'h52
`define IDX_AUTO_CTRL 8'h53
`define IDX_STATUS 8'h54
`define IDX_MASK 8'h55
`define IDX_IMP_RESULT 8'h56

// ----------------------------------------
// fields
// ----------------------------------------
`define MAIN_CTRL_RESET 8'h00
`define TIMING_CTRL_RESET 8'h00
`define AUTO_CTRL_RESET 8'h00
`define AUTO_EN_BIT 7
`define ST_SINGLE_DONE 0
`define ST_AUTO_DONE 1
`define ST_IMP_DONE 2
`define ST_WIDTH 3

// ----------------------------------------
// channel codes
// ----------------------------------------
`define CH_EXT0 4'h0
`define CH_EXT1 4'h1
`define CH_CELL_MON 4'h6
`define CH_TEMP 4'h7
`define CH_GND_REF 4'ha
`define CH_REF_SUPPLY 4'hb
`define CH_PULLUP 4'hd

// ----------------------------------------
// timing
// ----------------------------------------
`define CORE_CLK_MHZ 100
`define START_DELAY_US 60
`define OSC_DIVIDE 4
`define BASE_CONV_CYCLES 1024
`define RESULT_BITS 15
`define BASE_COUNT_BITS 11

// ----------------------------------------
// bus answers
// ----------------------------------------
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* File: design/adc_seq_pkg.sv */
// types shared by the converter sequencer files
package adc_seq_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WARMUP = 2'b01,
        ST_CONV = 2'b10
    } seq_state_t;

    typedef struct packed {
        logic convGo;
        logic convPowerOn;
        logic impedanceIntegrateGo;
        logic rsvd;
        logic [3:0] chanSel;
    } conv_main_ctrl_t;

    typedef struct packed {
        logic [5:0] rsvd;
        logic convLenSelHi;
        logic convLenSelLo;
    } conv_timing_ctrl_t;

endpackage : adc_seq_pkg

/* File: design/adc_clk_div.sv */
// operating-clock tick generator: one pulse per four rising front-end oscillator edges
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_regs.svh"

module adc_clk_div #(
    parameter int DIVIDE = `OSC_DIVIDE
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // oscillator sampled as a level
    input wire logic frontend_osc_clk,
    // one-cycle tick of the operating clock
    output logic phiTick
);

    logic oscPrev;
    logic [$clog2(DIVIDE)-1:0] edgeCnt;
    logic next_oscPrev;
    logic [$clog2(DIVIDE)-1:0] next_edgeCnt;
    logic next_phiTick;

    always_comb begin
        next_oscPrev = frontend_osc_clk;
        next_edgeCnt = edgeCnt;
        next_phiTick = 1'b0;
        if (frontend_osc_clk && !oscPrev) begin
            if (edgeCnt == $clog2(DIVIDE)'(DIVIDE - 1)) begin
                next_edgeCnt = '0;
                next_phiTick = 1'b1;
            end else begin
                next_edgeCnt = edgeCnt + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            oscPrev <= 1'b0;
            edgeCnt <= '0;
            phiTick <= 1'b0;
        end else begin
            oscPrev <= next_oscPrev;
            edgeCnt <= next_edgeCnt;
            phiTick <= next_phiTick;
        end
    end

endmodule : adc_clk_div

`default_nettype wire

/* File: design/deltasigma_adc_sequencer.sv */
// converter sequencer: register slave, conversion timing, auto mode and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_regs.svh"

// Behaviour
// - results are 15-bit, built by counting delta-sigma modulator ones.
// - one of seven channels is connected, per a legal channel select; none for other codes.
// - on completion the result goes into the result data registers.
// - single conversions start only on a software trigger; no hardware trigger.
// - operating clock is the oscillator divided by four.
// - a conversion lasts 1024, 2048, 4096 or 8192 operating cycles.
// - the two-bit length field of the timing register picks the length.
// - auto mode repeats conversions on its channel without triggers.
// - auto mode raises an interrupt and updates results at each completion.
// - impedance mode samples voltage and current over the same window.
// - start bit clears on completion; repeating needs a write of 0 then 1.
// - enable and start in one write begin converting 60 us later.
// - channel codes 0,1,6,7,a,b,d are legal; others are prohibited.
// - length codes 00..11 mean 1,2,4,8 ms; the register resets to zero.
module deltasigma_adc_sequencer #(
    parameter int START_DELAY_CYCLES = `START_DELAY_US * `CORE_CLK_MHZ
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // front end
    input wire logic frontend_osc_clk,
    input wire logic modBitVolt,
    input wire logic modBitCurr,
    // analog multiplexer control
    output logic [3:0] muxCode,
    output logic muxConnect,
    output logic convBusy,
    // interrupt
    output logic irq,
    // axi4-lite write address
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ----------------------------------------
    // operating clock
    // ----------------------------------------
    logic phiTick;

    adc_clk_div #(.DIVIDE(`OSC_DIVIDE)) u_div (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .frontend_osc_clk(frontend_osc_clk),
        .phiTick(phiTick)
    );

    // ----------------------------------------
    // bus handshake state
    // ----------------------------------------
    logic awHave, wHave;
    logic [7:0] awIdx;
    logic [7:0] wByte;
    logic wLane0;
    logic next_awHave, next_wHave, next_wLane0;
    logic [7:0] next_awIdx, next_wByte;
    logic next_awReady, next_wReady, next_bValid, next_arReady, next_rValid;
    logic [1:0] next_bResp, next_rResp;
    logic [31:0] next_rData;
    logic doWrite;
    logic wrMapped;
    logic [7:0] rdIdx;

    // ----------------------------------------
    // converter state
    // ----------------------------------------
    adc_seq_pkg::conv_main_ctrl_t mainCtrl, next_mainCtrl;
    adc_seq_pkg::conv_timing_ctrl_t timingCtrl, next_timingCtrl;
    adc_seq_pkg::seq_state_t state, next_state;
    logic [7:0] autoCtrl, next_autoCtrl;
    logic [`ST_WIDTH-1:0] status, next_status;
    logic [`ST_WIDTH-1:0] mask, next_mask;
    logic [`RESULT_BITS-1:0] result, next_result;
    logic [`RESULT_BITS-1:0] impResult, next_impResult;
    logic [13:0] cycleCnt, next_cycleCnt;
    logic [13:0] onesVolt, next_onesVolt;
    logic [13:0] onesCurr, next_onesCurr;
    logic [$clog2(START_DELAY_CYCLES+1)-1:0] delayCnt, next_delayCnt;
    logic runAuto, next_runAuto;
    logic runImp, next_runImp;
    logic [3:0] next_muxCode;
    logic next_muxConnect, next_irq;
    logic [13:0] convLen;
    logic convEnd;

    function automatic logic legalChan(input logic [3:0] code);
        case (code)
            `CH_EXT0, `CH_EXT1, `CH_CELL_MON, `CH_TEMP: legalChan = 1'b1;
            `CH_GND_REF, `CH_REF_SUPPLY, `CH_PULLUP: legalChan = 1'b1;
            default: legalChan = 1'b0;
        endcase
    endfunction : legalChan

    // scale the ones count of the window to full 15-bit range, saturating at the top
    function automatic logic [`RESULT_BITS-1:0] scale(input logic [13:0] ones,
                                                      input logic [1:0] sel);
        logic [17:0] wide;
        wide = {4'h0, ones} << (`RESULT_BITS - `BASE_COUNT_BITS + 1 - 18'(sel));
        scale = (wide > 18'h07fff) ? 15'h7fff : wide[`RESULT_BITS-1:0];
    endfunction : scale

    // ----------------------------------------
    // bus slave
    // ----------------------------------------
    // address and data are taken in either order; the write lands once both are held
    always_comb begin
        next_awHave = awHave;
        next_wHave = wHave;
        next_awIdx = awIdx;
        next_wByte = wByte;
        next_wLane0 = wLane0;
        next_awReady = s_axi_awready;
        next_wReady = s_axi_wready;
        next_bValid = s_axi_bvalid;
        next_bResp = s_axi_bresp;
        next_arReady = s_axi_arready;
        next_rValid = s_axi_rvalid;
        next_rResp = s_axi_rresp;
        next_rData = s_axi_rdata;
        rdIdx = s_axi_araddr[9:2];
        doWrite = awHave && wHave && !s_axi_bvalid;
        wrMapped = (awIdx >= `IDX_MAIN_CTRL) && (awIdx <= `IDX_IMP_RESULT)
                   && (awIdx != `IDX_RESULT) && (awIdx != `IDX_IMP_RESULT);
        if (s_axi_awvalid && s_axi_awready) begin
            next_awHave = 1'b1;
            next_awIdx = (s_axi_awaddr[31:10] == 22'h0) ? s_axi_awaddr[9:2] : 8'hff;
            next_awReady = 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_wHave = 1'b1;
            next_wByte = s_axi_wdata[7:0];
            next_wLane0 = s_axi_wstrb[0];
            next_wReady = 1'b0;
        end
        if (doWrite) begin
            next_awHave = 1'b0;
            next_wHave = 1'b0;
            next_bValid = 1'b1;
            next_bResp = wrMapped ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bValid = 1'b0;
            next_awReady = 1'b1;
            next_wReady = 1'b1;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_arReady = 1'b0;
            next_rValid = 1'b1;
            next_rResp = `RESP_OKAY;
            next_rData = 32'h0;
            if (s_axi_araddr[31:10] != 22'h0) begin
                next_rResp = `RESP_SLVERR;
            end else begin
                case (rdIdx)
                    `IDX_MAIN_CTRL: next_rData = {24'h0, mainCtrl};
                    `IDX_TIMING_CTRL: next_rData = {24'h0, timingCtrl};
                    `IDX_RESULT: next_rData = {17'h0, result};
                    `IDX_AUTO_CTRL: next_rData = {24'h0, autoCtrl};
                    `IDX_STATUS: next_rData = {29'h0, status};
                    `IDX_MASK: next_rData = {29'h0, mask};
                    `IDX_IMP_RESULT: next_rData = {17'h0, impResult};
                    default: next_rResp = `RESP_SLVERR;
                endcase
            end
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rValid = 1'b0;
            next_arReady = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            awHave <= 1'b0;
            wHave <= 1'b0;
            awIdx <= 8'h00;
            wByte <= 8'h00;
            wLane0 <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `RESP_OKAY;
            s_axi_rdata <= 32'h0;
        end else begin
            awHave <= next_awHave;
            wHave <= next_wHave;
            awIdx <= next_awIdx;
            wByte <= next_wByte;
            wLane0 <= next_wLane0;
            s_axi_awready <= next_awReady;
            s_axi_wready <= next_wReady;
            s_axi_bvalid <= next_bValid;
            s_axi_bresp <= next_bResp;
            s_axi_arready <= next_arReady;
            s_axi_rvalid <= next_rValid;
            s_axi_rresp <= next_rResp;
            s_axi_rdata <= next_rData;
        end
    end

    // ----------------------------------------
    // registers and conversion sequencing
    // ----------------------------------------
    assign convLen = 14'(`BASE_CONV_CYCLES) << {timingCtrl.convLenSelHi,
                                                timingCtrl.convLenSelLo};
    assign convEnd = (state == adc_seq_pkg::ST_CONV) && phiTick && (cycleCnt == convLen - 1'b1);

    always_comb begin
        next_mainCtrl = mainCtrl;
        next_timingCtrl = timingCtrl;
        next_autoCtrl = autoCtrl;
        next_status = status;
        next_mask = mask;
        next_result = result;
        next_impResult = impResult;
        next_state = state;
        next_cycleCnt = cycleCnt;
        next_onesVolt = onesVolt;
        next_onesCurr = onesCurr;
        next_delayCnt = delayCnt;
        next_runAuto = runAuto;
        next_runImp = runImp;
        next_muxCode = muxCode;
        next_muxConnect = muxConnect;
        if (doWrite && wLane0) begin
            case (awIdx)
                `IDX_MAIN_CTRL: begin
                    next_mainCtrl = adc_seq_pkg::conv_main_ctrl_t'(wByte);
                    next_mainCtrl.rsvd = 1'b0;
                    // a rising start bit only counts while idle and enabled
                    if (state == adc_seq_pkg::ST_IDLE && wByte[7] && !mainCtrl.convGo
                        && wByte[6]) begin
                        next_runAuto = 1'b0;
                        next_runImp = wByte[5];
                        next_muxCode = wByte[3:0];
                        next_delayCnt = '0;
                        next_cycleCnt = '0;
                        next_onesVolt = '0;
                        next_onesCurr = '0;
                        // enable and start together wait for the modulator to settle
                        next_state = mainCtrl.convPowerOn ? adc_seq_pkg::ST_CONV
                                                          : adc_seq_pkg::ST_WARMUP;
                        next_muxConnect = mainCtrl.convPowerOn && legalChan(wByte[3:0]);
                    end
                end
                `IDX_TIMING_CTRL: next_timingCtrl = {6'h00, wByte[1:0]};
                `IDX_AUTO_CTRL: next_autoCtrl = {wByte[7], 3'h0, wByte[3:0]};
                `IDX_STATUS: next_status = status & ~wByte[`ST_WIDTH-1:0];
                `IDX_MASK: next_mask = wByte[`ST_WIDTH-1:0];
                default: next_mask = mask;
            endcase
        end
        case (state)
            adc_seq_pkg::ST_IDLE: begin
                next_muxConnect = (next_state == adc_seq_pkg::ST_CONV) && next_muxConnect;
                if (next_state == adc_seq_pkg::ST_IDLE && autoCtrl[`AUTO_EN_BIT]
                    && mainCtrl.convPowerOn) begin
                    next_state = adc_seq_pkg::ST_CONV;
                    next_runAuto = 1'b1;
                    next_runImp = mainCtrl.impedanceIntegrateGo;
                    next_muxCode = autoCtrl[3:0];
                    next_muxConnect = legalChan(autoCtrl[3:0]);
                    next_cycleCnt = '0;
                    next_onesVolt = '0;
                    next_onesCurr = '0;
                end
            end
            adc_seq_pkg::ST_WARMUP: begin
                next_delayCnt = delayCnt + 1'b1;
                if (!next_mainCtrl.convPowerOn) begin
                    next_state = adc_seq_pkg::ST_IDLE;
                    next_mainCtrl.convGo = 1'b0;
                end else if (delayCnt == ($bits(delayCnt))'(START_DELAY_CYCLES - 1)) begin
                    next_state = adc_seq_pkg::ST_CONV;
                    next_muxConnect = legalChan(muxCode);
                end
            end
            adc_seq_pkg::ST_CONV: begin
                if (phiTick) begin
                    next_cycleCnt = cycleCnt + 1'b1;
                    // both modulators integrate over one shared window
                    next_onesVolt = onesVolt + {13'h0, modBitVolt};
                    next_onesCurr = onesCurr + {13'h0, modBitCurr & runImp};
                end
                if (!next_mainCtrl.convPowerOn) begin
                    next_state = adc_seq_pkg::ST_IDLE;
                    next_muxConnect = 1'b0;
                    next_mainCtrl.convGo = 1'b0;
                end else if (convEnd) begin
                    next_state = adc_seq_pkg::ST_IDLE;
                    next_muxConnect = 1'b0;
                    next_result = scale(next_onesVolt, {timingCtrl.convLenSelHi,
                                                        timingCtrl.convLenSelLo});
                    if (runImp) begin
                        next_impResult = scale(next_onesCurr, {timingCtrl.convLenSelHi,
                                                               timingCtrl.convLenSelLo});
                        next_status[`ST_IMP_DONE] = 1'b1;
                    end
                    if (runAuto) begin
                        next_status[`ST_AUTO_DONE] = 1'b1;
                    end else begin
                        next_status[`ST_SINGLE_DONE] = 1'b1;
                        next_mainCtrl.convGo = 1'b0;
                    end
                end
            end
            default: next_state = adc_seq_pkg::ST_IDLE;
        endcase
        next_irq = |(next_status & next_mask);
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mainCtrl <= `MAIN_CTRL_RESET;
            timingCtrl <= `TIMING_CTRL_RESET;
            autoCtrl <= `AUTO_CTRL_RESET;
            status <= '0;
            mask <= '0;
            result <= '0;
            impResult <= '0;
            state <= adc_seq_pkg::ST_IDLE;
            cycleCnt <= '0;
            onesVolt <= '0;
            onesCurr <= '0;
            delayCnt <= '0;
            runAuto <= 1'b0;
            runImp <= 1'b0;
            muxCode <= `CH_EXT0;
            muxConnect <= 1'b0;
            convBusy <= 1'b0;
            irq <= 1'b0;
        end else begin
            mainCtrl <= next_mainCtrl;
            timingCtrl <= next_timingCtrl;
            autoCtrl <= next_autoCtrl;
            status <= next_status;
            mask <= next_mask;
            result <= next_result;
            impResult <= next_impResult;
            state <= next_state;
            cycleCnt <= next_cycleCnt;
            onesVolt <= next_onesVolt;
            onesCurr <= next_onesCurr;
            delayCnt <= next_delayCnt;
            runAuto <= next_runAuto;
            runImp <= next_runImp;
            muxCode <= next_muxCode;
            muxConnect <= next_muxConnect;
            convBusy <= (next_state != adc_seq_pkg::ST_IDLE);
            irq <= next_irq;
        end
    end

endmodule : deltasigma_adc_sequencer

`default_nettype wire

/* File: bench/adc_seq_properties.sv */
// port-level assertions for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_seq_properties (
    input wire logic core_clk, sys_rst, convBusy, muxConnect, irq,
    input wire logic [3:0] muxCode,
    input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_out_of_reset: assert property ($fell(sys_rst) |-> !irq && !convBusy && !muxConnect)
        else $error("outputs not idle after reset");
    a_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
        else $error("no write response two cycles after both taken");
    a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
        else $error("no read data one cycle after address taken");
    a_ready_drops: assert property (wr_taken |=> !s_axi_awready && !s_axi_wready)
        else $error("write channels still ready while a write is open");
    a_mux_busy: assert property (muxConnect |-> convBusy)
        else $error("channel connected while idle");
    a_mux_legal: assert property (muxConnect |-> muxCode inside {4'h0, 4'h1, 4'h6, 4'h7, 4'ha, 4'hb, 4'hd})
        else $error("prohibited channel connected");
    a_mux_steady: assert property (muxConnect && $past(muxConnect) |-> $stable(muxCode))
        else $error("channel changed inside a conversion");
    a_conv_span: assert property ($rose(convBusy) |-> convBusy [*8])
        else $error("conversion ended too early");
endmodule : adc_seq_properties
`default_nettype wire

/* File: bench/adc_frontend_model.sv */
// front-end stand-in: oscillator and modulator bit streams
`timescale 1ns/1ps
`default_nettype none
module adc_frontend_model #(
    parameter int HALF_NS = 15
) (
    output logic oscClk,
    output logic voltBit,
    output logic currBit
);
    int edges;
    // full-scale voltage so the result saturates; current at half density
    // slower than half the core clock, so every edge is seen
    initial begin
        oscClk = 1'b0;
        voltBit = 1'b1;
        currBit = 1'b0;
        edges = 0;
        // offset keeps every oscillator edge off the core clock edges
        #1;
        forever #(HALF_NS) oscClk = ~oscClk;
    end
    always @(posedge oscClk) begin
        edges = edges + 1;
        if (edges % 4 == 0) currBit = ~currBit;
    end
endmodule : adc_frontend_model
`default_nettype wire

/* File: bench/deltasigma_adc_sequencer_test.sv */
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_regs.svh"
module deltasigma_adc_sequencer_test;
    localparam int DLY = 20;
    localparam int TICK = 12;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic osc, vBit, cBit, muxConnect, convBusy, irq;
    logic [3:0] muxCode;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, rd;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int fail_count = 0, compares = 0, cycles = 0, n;
    logic [7:0] idx [5] = '{8'h50, 8'h51, 8'h53, 8'h54, 8'h55};

    always #5 core_clk = ~core_clk;
    adc_frontend_model u_fe (.oscClk(osc), .voltBit(vBit), .currBit(cBit));
    deltasigma_adc_sequencer #(.START_DELAY_CYCLES(DLY)) u_dut (.core_clk, .sys_rst,
        .frontend_osc_clk(osc), .modBitVolt(vBit), .modBitCurr(cBit), .muxCode,
        .muxConnect, .convBusy, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    task automatic chk(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("ERROR %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic wr(input logic [7:0] i, input logic [31:0] d, input logic [1:0] er);
        @(posedge core_clk);
        s_axi_awaddr <= {22'h0, i, 2'b00};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp === er, "write response");
    endtask : wr
    task automatic rdr(input logic [7:0] i, input logic [1:0] er);
        @(posedge core_clk);
        s_axi_araddr <= {22'h0, i, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        chk(s_axi_rresp === er, "read response");
    endtask : rdr
    // tick phase against the core clock is free, hence the window
    task automatic wait_idle(input int lo, input int hi);
        while (convBusy !== 1'b0 && n < hi + 100) begin
            @(posedge core_clk);
            n++;
        end
        chk(n >= lo && n <= hi, "conversion length");
    endtask : wait_idle

    task automatic t_reset_vals();
        foreach (idx[j]) begin
            rdr(idx[j], `RESP_OKAY);
            chk(rd === 32'h0, "reset value");
        end
        rdr(8'h7f, `RESP_SLVERR);
        wr(`IDX_RESULT, 32'h1, `RESP_SLVERR);
        s_axi_wstrb <= 4'h0;
        wr(`IDX_MASK, 32'h7, `RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rdr(`IDX_MASK, `RESP_OKAY);
        chk(rd === 32'h0, "write without low lane landed");
        wr(`IDX_MAIN_CTRL, 32'h40, `RESP_OKAY);
        repeat (DLY + 10) @(posedge core_clk);
        chk(convBusy === 1'b0, "started without trigger");
        wr(`IDX_MAIN_CTRL, 32'h00, `RESP_OKAY);
    endtask : t_reset_vals
    task automatic t_single();
        wr(`IDX_TIMING_CTRL, 32'h0, `RESP_OKAY);
        wr(`IDX_MAIN_CTRL, 32'he6, `RESP_OKAY);
        repeat (DLY + 40) @(posedge core_clk);
        chk(muxCode === `CH_CELL_MON && muxConnect === 1'b1, "mux");
        n = DLY + 40;
        wait_idle(DLY + 1024 * TICK - 30, DLY + 1024 * TICK + 40);
        rdr(`IDX_MAIN_CTRL, `RESP_OKAY);
        chk(rd[7] === 1'b0 && rd[3:0] === 4'h6, "go not cleared");
        rdr(`IDX_RESULT, `RESP_OKAY);
        chk(rd === 32'h7fff, "result");
        rdr(`IDX_IMP_RESULT, `RESP_OKAY);
        chk(rd >= 32'h3fc0 && rd <= 32'h4040, "current result");
        rdr(`IDX_STATUS, `RESP_OKAY);
        chk(rd[2:0] === 3'b101 && irq === 1'b0, "done flags");
    endtask : t_single
    task automatic t_repeat();
        wr(`IDX_TIMING_CTRL, 32'h1, `RESP_OKAY);
        wr(`IDX_MAIN_CTRL, 32'h4c, `RESP_OKAY);
        wr(`IDX_MAIN_CTRL, 32'hcc, `RESP_OKAY);
        repeat (40) @(posedge core_clk);
        chk(convBusy === 1'b1 && muxConnect === 1'b0, "prohibited code");
        wr(`IDX_MAIN_CTRL, 32'h4c, `RESP_OKAY);
        wr(`IDX_MAIN_CTRL, 32'hc6, `RESP_OKAY);
        chk(muxCode === 4'hc && muxConnect === 1'b0, "trigger taken while busy");
        n = 48;
        wait_idle(2048 * TICK - 30, 2048 * TICK + 40);
    endtask : t_repeat
    task automatic t_auto();
        wr(`IDX_STATUS, 32'h7, `RESP_OKAY);
        wr(`IDX_MASK, 32'h2, `RESP_OKAY);
        wr(`IDX_TIMING_CTRL, 32'h0, `RESP_OKAY);
        wr(`IDX_MAIN_CTRL, 32'h47, `RESP_OKAY);
        wr(`IDX_AUTO_CTRL, 32'h87, `RESP_OKAY);
        n = 0;
        while (irq !== 1'b1 && n < 1100 * TICK) begin
            @(posedge core_clk);
            n++;
        end
        chk(n >= 1024 * TICK - 30 && n <= 1024 * TICK + 40, "auto interrupt");
        rdr(`IDX_RESULT, `RESP_OKAY);
        chk(rd === 32'h7fff, "auto result");
        wr(`IDX_MASK, 32'h0, `RESP_OKAY);
        @(posedge core_clk);
        chk(irq === 1'b0, "masked");
        wr(`IDX_MASK, 32'h2, `RESP_OKAY);
        wr(`IDX_STATUS, 32'h2, `RESP_OKAY);
        @(posedge core_clk);
        chk(irq === 1'b0, "cleared");
        wr(`IDX_AUTO_CTRL, 32'h0, `RESP_OKAY);
    endtask : t_auto

    task automatic close_out();
        $display("mismatches %0d comparisons %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    initial begin
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_reset_vals();
        t_single();
        t_repeat();
        t_auto();
        close_out();
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 80000) begin
            fail_count++;
            close_out();
        end
    end
endmodule : deltasigma_adc_sequencer_test
bind deltasigma_adc_sequencer adc_seq_properties u_props (.core_clk, .sys_rst, .convBusy,
    .muxConnect, .irq, .muxCode, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
`default_nettype wire
